// ---- hw/bpu_consts.vh ----
`ifndef BPU_CONSTS_VH
`define BPU_CONSTS_VH
// Global history and far-page field
`define BPU_GHW       26
`define BPU_FP_HI     28
`define BPU_FP_LO     12
`define BPU_FW_DEPTH  6'h10
// Target buffer entry layout (valid bits held apart)
`define BPU_EW        33
`define BPU_E_OFF     32:27
`define BPU_E_OFF5    32
`define BPU_E_KIND    26:24
`define BPU_E_DYN     23
`define BPU_E_FAR     22
`define BPU_E_ITA     21
`define BPU_E_LEN     20:17
`define BPU_E_FPI     16:12
`define BPU_E_TLO     11:0
// Compressed marker kept in the shared cache
`define BPU_MKW       29
`define BPU_MK_V      28
`define BPU_MK_FAR    17
// Branch kinds
`define BPU_K_COND    3'h0
`define BPU_K_JMP     3'h1
`define BPU_K_CALL    3'h2
`define BPU_K_RET     3'h3
`define BPU_K_IND     3'h4
`define BPU_K_ICALL   3'h5
// Bubble and penalty cycle counts, direction counter reset value
`define BPU_BUB_SP    4'h1
`define BPU_BUB_DN    4'h2
`define BPU_BUB_IND   4'h3
`define BPU_BUB_FIXDN 4'h4
`define BPU_MISP      4'hE
`define BPU_DP_INIT   2'h2
`endif

// ---- hw/bpu_branch_prediction_unit.v ----
`timescale 1ns/1ps
`include "bpu_consts.vh"
// Notes on behaviour
// - No taken branch in block gives next 32-byte block, else the target.
// - Sparse buffer: first two branches per 64-byte line, 1024 entries.
// - Dense buffer: 1024 entries, two per 8-byte chunk of one line.
// - Taken sparse prediction costs a one-cycle bubble.
// - Dense chain: first costs two cycles, each later one more.
// - Indirect targets add three cycles to the bubble; any fix-up costs four.
// - Misprediction holds fetch at least fourteen cycles.
// - Fix-up redirects wrong direct targets once immediates are fetched.
// - Far-page array keeps bits 28:12 of 32 targets, sparse only.
// - Dense far-page and 28-bit crossing sparse targets are fixed up.
// - Evicted code-only line sends its two sparse markers out.
// - Markers restored on refill only when the cache says still valid.
// - 16-entry return stack: calls push next address, returns pop.
// - Return stack recovered on flush, invalidated when unrecoverable.
// - Zero-displacement calls push like any other call.
// - One-byte returns predicted like any other return.
// - 512-entry indirect array indexed with 26-bit global history.
// - Single-target indirect uses the array only across 28-bit blocks.
// - Dynamic direction predictor for conditionals seen both ways.
// - Conditionals go unmarked, always-taken, then dynamic.
// - 16-entry window FIFO: one per line plus one per dense branch.
// - Fetch stalls while the window FIFO lacks room.
module bpu_branch_prediction_unit (
   // Clock and reset
   input  wire                   i_clk,
   input  wire                   i_rst,
   // Fetch address stream with checkpoints
   output wire                   o_fetch_valid,
   output wire [31:0]            o_fetch_addr,
   output wire [3:0]             o_fetch_fw_idx,
   output wire [`BPU_GHW-1:0]    o_fetch_ghist,
   output wire [3:0]             o_fetch_ras_ptr,
   output wire [31:0]            o_fetch_ras_top,
   // Predecode of direct branches
   input  wire                   i_pd_valid,
   input  wire [31:0]            i_pd_addr,
   input  wire                   i_pd_direct,
   input  wire                   i_pd_imm_done,
   input  wire [31:0]            i_pd_tgt,
   // Resolved branch training
   input  wire                   i_upd_valid,
   input  wire [31:0]            i_upd_addr,
   input  wire [2:0]             i_upd_kind,
   input  wire [3:0]             i_upd_len,
   input  wire                   i_upd_taken,
   input  wire [31:0]            i_upd_tgt,
   input  wire [`BPU_GHW-1:0]    i_upd_ghist,
   // Misprediction flush
   input  wire                   i_mis_valid,
   input  wire [31:0]            i_mis_addr,
   input  wire                   i_mis_cond,
   input  wire                   i_mis_taken,
   input  wire [`BPU_GHW-1:0]    i_mis_ghist,
   input  wire [3:0]             i_mis_fw_idx,
   input  wire [3:0]             i_mis_ras_ptr,
   input  wire [31:0]            i_mis_ras_top,
   // Retirement
   input  wire                   i_ret_valid,
   // Marker caching in the shared cache
   input  wire                   i_evict_valid,
   input  wire [25:0]            i_evict_line,
   input  wire                   i_evict_code_only,
   output wire                   o_l2m_valid,
   output wire [25:0]            o_l2m_line,
   output wire [2*`BPU_MKW-1:0]  o_l2m_data,
   input  wire                   i_fill_valid,
   input  wire [25:0]            i_fill_line,
   input  wire                   i_fill_mark_ok,
   input  wire [2*`BPU_MKW-1:0]  i_fill_mark
);

   // Storage
   reg [`BPU_EW-1:0]     sp_mem [0:1023];
   reg [`BPU_EW-1:0]     dn_mem [0:1023];
   reg [1023:0]          sp_v_q;
   reg [1023:0]          dn_v_q;
   reg [1:0]             dp_mem [0:1023];
   reg [31:0]            it_mem [0:511];
   reg [16:0]            fp_mem [0:31];
   reg [4:0]             fp_ptr_q;
   reg [31:0]            ras_mem [0:15];
   reg [15:0]            ras_v_q;
   reg [3:0]             ras_ptr_q;
   reg                   ras_lost_q;
   reg [25:0]            fw_line_mem [0:15];
   reg [4:0]             fw_head_q;
   reg [4:0]             fw_tail_q;
   reg [25:0]            fw_last_q;
   reg                   fw_last_v_q;
   reg [31:0]            pc_q;
   reg [3:0]             bub_q;
   reg [`BPU_GHW-1:0]    ghist_q;
   reg                   lp_v_q;
   reg [31:0]            lp_addr_q;
   reg [31:0]            lp_tgt_q;
   reg                   lp_dense_q;
   reg                   l2m_v_q;
   reg [25:0]            l2m_line_q;
   reg [2*`BPU_MKW-1:0]  l2m_data_q;
   integer               i;
   integer               j;

   // History folded into table indexes; marker packing
   function [9:0] dp_idx(input [31:0] a, input [`BPU_GHW-1:0] g);
      dp_idx = a[11:2] ^ g[9:0] ^ g[19:10] ^ {4'h0, g[25:20]};
   endfunction
   function [8:0] it_idx(input [31:0] a, input [`BPU_GHW-1:0] g);
      it_idx = a[10:2] ^ g[8:0] ^ g[17:9] ^ {1'b0, g[25:18]};
   endfunction
   function [`BPU_MKW-1:0] mk(input v, input [`BPU_EW-1:0] e);
      mk = {v, e[32:17], e[`BPU_E_TLO]};
   endfunction

   // Scan sparse then dense entries of the current block
   reg               found;
   reg               sel_dn;
   reg               any_nt;
   reg [`BPU_EW-1:0] sel_e;
   reg [`BPU_EW-1:0] ce;
   reg               cv;
   reg               ctk;
   reg [9:0]         ci;
   reg [3:0]         jj;
   reg [3:0]         n_dn;
   always @* begin
      found = 1'b0;
      sel_dn = 1'b0;
      any_nt = 1'b0;
      sel_e = {`BPU_EW{1'b0}};
      ce = {`BPU_EW{1'b0}};
      cv = 1'b0;
      ctk = 1'b0;
      ci = 10'h000;
      jj = 4'h0;
      n_dn = 4'h0;
      for (j = 0; j < 10; j = j + 1) begin
         jj = j[3:0];
         if (j < 2) begin
            ci = {pc_q[14:6], jj[0]};
            ce = sp_mem[ci];
            cv = sp_v_q[ci];
         end else begin
            jj = jj - 4'h2;
            ci = {pc_q[11:5], jj[2:0]};
            ce = dn_mem[ci];
            cv = dn_v_q[ci];
         end
         cv = cv && (ce[`BPU_E_OFF] >= pc_q[5:0])
                 && (ce[`BPU_E_OFF5] == pc_q[5]);
         case (ce[`BPU_E_KIND])
            // Unmarked ones never get here; marked start always-taken
            `BPU_K_COND: ctk = !ce[`BPU_E_DYN] ||
               dp_mem[dp_idx({pc_q[31:6], ce[`BPU_E_OFF]}, ghist_q)][1];
            `BPU_K_RET:  ctk = ras_v_q[ras_ptr_q];
            default:     ctk = 1'b1;
         endcase
         if (!found && cv) begin
            if (j >= 2) n_dn = n_dn + 4'h1;
            if (ctk) begin
               found = 1'b1;
               sel_e = ce;
               sel_dn = (j >= 2);
            end else if (ce[`BPU_E_KIND] == `BPU_K_COND) begin
               any_nt = 1'b1;
            end
         end
      end
   end

   // Target, bubble and window demand of this block
   wire [31:0] br_addr = {pc_q[31:6], sel_e[`BPU_E_OFF]};
   wire [2:0]  sel_k   = sel_e[`BPU_E_KIND];
   wire        sel_call = (sel_k == `BPU_K_CALL) || (sel_k == `BPU_K_ICALL);
   wire        sel_ret  = (sel_k == `BPU_K_RET);
   wire        sel_cond = (sel_k == `BPU_K_COND);
   reg  [31:0] p_tgt;
   reg  [3:0]  p_bub;
   always @* begin
      if (!found)
         p_tgt = {pc_q[31:5] + 27'h1, 5'h00};
      else if (sel_ret)
         p_tgt = ras_mem[ras_ptr_q];
      else if (sel_e[`BPU_E_ITA])
         p_tgt = it_mem[it_idx(br_addr, ghist_q)];
      else if (sel_e[`BPU_E_FAR] && !sel_dn)
         p_tgt = {pc_q[31:29], fp_mem[sel_e[`BPU_E_FPI]],
                  sel_e[`BPU_E_TLO]};
      else
         p_tgt = {pc_q[31:12], sel_e[`BPU_E_TLO]};
      if (n_dn != 4'h0)
         p_bub = n_dn + `BPU_BUB_DN - 4'h1;
      else if (found)
         p_bub = `BPU_BUB_SP;
      else
         p_bub = 4'h0;
      if (found && sel_e[`BPU_E_ITA])
         p_bub = p_bub + `BPU_BUB_IND;
   end

   wire [4:0] fw_cnt  = fw_tail_q - fw_head_q;
   wire       new_ln  = !fw_last_v_q || (fw_last_q != pc_q[31:6]);
   // One entry per line, one more per dense branch
   wire [5:0] fw_need = new_ln ? {2'h0, n_dn} + 6'h1 : {2'h0, n_dn};
   wire       fw_stall = ({1'b0, fw_cnt} + fw_need) > `BPU_FW_DEPTH;

   // Fix-up only once the branch's immediates are all in
   wire fix = i_pd_valid && i_pd_direct && i_pd_imm_done && lp_v_q &&
              (lp_addr_q == i_pd_addr) && (lp_tgt_q != i_pd_tgt);
   wire fix_oop = lp_dense_q && (i_pd_tgt[31:12] != i_pd_addr[31:12]);
   wire [3:0] fix_bub = fix_oop ? `BPU_BUB_FIXDN
                                : `BPU_BUB_SP + `BPU_BUB_IND;
   wire adv = !i_mis_valid && !fix && (bub_q == 4'h0) && !fw_stall;
   wire [3:0] push_ptr = ras_ptr_q + 4'h1;
   wire [4:0] fw_keep = {1'b0, i_mis_fw_idx - fw_head_q[3:0]} + 5'h1;

   assign o_fetch_valid   = adv;
   assign o_fetch_addr    = pc_q;
   assign o_fetch_fw_idx  = new_ln ? fw_tail_q[3:0] : fw_tail_q[3:0] - 4'h1;
   assign o_fetch_ghist   = ghist_q;
   assign o_fetch_ras_ptr = ras_ptr_q;
   assign o_fetch_ras_top = ras_mem[ras_ptr_q];
   assign o_l2m_valid     = l2m_v_q;
   assign o_l2m_line      = l2m_line_q;
   assign o_l2m_data      = l2m_data_q;

   // Next-address pipeline, return stack, history and window FIFO
   always @(posedge i_clk) begin
      if (i_rst) begin
         pc_q <= 32'h00000000;
         bub_q <= 4'h0;
         ghist_q <= {`BPU_GHW{1'b0}};
         ras_v_q <= 16'h0000;
         ras_ptr_q <= 4'h0;
         ras_lost_q <= 1'b0;
         fw_head_q <= 5'h00;
         fw_tail_q <= 5'h00;
         fw_last_q <= 26'h0000000;
         fw_last_v_q <= 1'b0;
         lp_v_q <= 1'b0;
         lp_addr_q <= 32'h00000000;
         lp_tgt_q <= 32'h00000000;
         lp_dense_q <= 1'b0;
      end else begin
         if (i_ret_valid && fw_cnt != 5'h00)
            fw_head_q <= fw_head_q + 5'h01;
         if (i_mis_valid) begin
            pc_q <= i_mis_addr;
            bub_q <= `BPU_MISP;
            ghist_q <= i_mis_cond ? {i_mis_ghist[`BPU_GHW-2:0], i_mis_taken}
                                  : i_mis_ghist;
            fw_tail_q <= fw_head_q + fw_keep;
            fw_last_v_q <= 1'b0;
            lp_v_q <= 1'b0;
            ras_ptr_q <= i_mis_ras_ptr;
            ras_mem[i_mis_ras_ptr] <= i_mis_ras_top;
            ras_lost_q <= 1'b0;
            // Overwritten entries cannot be rebuilt, so drop them all
            if (ras_lost_q)
               ras_v_q <= 16'h0000;
            else
               ras_v_q[i_mis_ras_ptr] <= 1'b1;
         end else if (fix) begin
            pc_q <= i_pd_tgt;
            bub_q <= fix_bub;
            fw_last_v_q <= 1'b0;
            lp_v_q <= 1'b0;
         end else if (bub_q != 4'h0) begin
            bub_q <= bub_q - 4'h1;
         end else if (!fw_stall) begin
            pc_q <= p_tgt;
            bub_q <= p_bub;
            fw_line_mem[fw_tail_q[3:0]] <= pc_q[31:6];
            fw_tail_q <= fw_tail_q + fw_need[4:0];
            fw_last_q <= pc_q[31:6];
            fw_last_v_q <= !found;
            if (found) begin
               lp_v_q <= 1'b1;
               lp_addr_q <= br_addr;
               lp_tgt_q <= p_tgt;
               lp_dense_q <= sel_dn;
            end
            if (found && sel_cond)
               ghist_q <= {ghist_q[`BPU_GHW-2:0], 1'b1};
            else if (any_nt)
               ghist_q <= {ghist_q[`BPU_GHW-2:0], 1'b0};
            // Any call pushes, zero displacement included
            if (found && sel_call) begin
               ras_ptr_q <= push_ptr;
               ras_mem[push_ptr] <= br_addr +
                  {28'h0000000, sel_e[`BPU_E_LEN]};
               ras_v_q[push_ptr] <= 1'b1;
               if (ras_v_q[push_ptr])
                  ras_lost_q <= 1'b1;
            end else if (found && sel_ret) begin
               ras_v_q[ras_ptr_q] <= 1'b0;
               ras_ptr_q <= ras_ptr_q - 4'h1;
            end
         end
      end
   end

   // Training lookup of the resolved branch
   wire [8:0] ul   = i_upd_addr[14:6];
   wire [8:0] ud   = i_upd_addr[11:3];
   wire [5:0] uoff = i_upd_addr[5:0];
   wire [`BPU_EW-1:0] s0 = sp_mem[{ul, 1'b0}];
   wire [`BPU_EW-1:0] s1 = sp_mem[{ul, 1'b1}];
   wire [`BPU_EW-1:0] d0 = dn_mem[{ud, 1'b0}];
   wire [`BPU_EW-1:0] d1 = dn_mem[{ud, 1'b1}];
   wire sh0 = sp_v_q[{ul, 1'b0}] && s0[`BPU_E_OFF] == uoff;
   wire sh1 = sp_v_q[{ul, 1'b1}] && s1[`BPU_E_OFF] == uoff;
   wire dh0 = dn_v_q[{ud, 1'b0}] && d0[`BPU_E_OFF] == uoff;
   wire dh1 = dn_v_q[{ud, 1'b1}] && d1[`BPU_E_OFF] == uoff;
   wire hit = sh0 | sh1 | dh0 | dh1;
   wire [`BPU_EW-1:0] old = sh0 ? s0 : sh1 ? s1 : dh0 ? d0 : d1;
   wire sp_free = !sp_v_q[{ul, 1'b0}] || !sp_v_q[{ul, 1'b1}];
   // First two branches of a line stay sparse, the rest go dense
   wire in_sp = sh0 | sh1 | (!hit && sp_free);
   wire sp_slot = sh0 ? 1'b0 : sh1 ? 1'b1 : sp_v_q[{ul, 1'b0}];
   wire dn_slot = dh0 ? 1'b0 : dh1 ? 1'b1 :
                  dn_v_q[{ud, 1'b0}] ? uoff[2] : 1'b0;
   wire u_cond = (i_upd_kind == `BPU_K_COND);
   wire u_ind  = (i_upd_kind == `BPU_K_IND) || (i_upd_kind == `BPU_K_ICALL);
   wire u_inpg = (i_upd_tgt[31:12] == i_upd_addr[31:12]);
   wire u_x28  = (i_upd_tgt[31:29] != i_upd_addr[31:29]);
   wire u_dyn  = u_cond && hit && (old[`BPU_E_DYN] || !i_upd_taken);
   wire u_ita  = u_ind && (u_x28 || (hit && (old[`BPU_E_ITA] ||
                 old[`BPU_E_TLO] != i_upd_tgt[`BPU_E_TLO])));
   // Crossing targets are left for the fix-up calculator
   wire u_far  = in_sp && !u_ita && !u_inpg && !u_x28;
   wire u_reuse = hit && old[`BPU_E_FAR];
   wire [4:0] u_fpi = u_reuse ? old[`BPU_E_FPI] : fp_ptr_q;
   wire u_wr = i_upd_valid && (hit || !u_cond || i_upd_taken);
   wire [`BPU_EW-1:0] u_ent = {uoff, i_upd_kind, u_dyn, u_far, u_ita,
                               i_upd_len, u_fpi, i_upd_tgt[`BPU_E_TLO]};
   wire [9:0] u_dp = dp_idx(i_upd_addr, i_upd_ghist);
   wire [8:0] fi   = i_fill_line[8:0];
   wire [`BPU_MKW-1:0] fm0 = i_fill_mark[`BPU_MKW-1:0];
   wire [`BPU_MKW-1:0] fm1 = i_fill_mark[2*`BPU_MKW-1:`BPU_MKW];

   // Prediction tables and marker caching
   always @(posedge i_clk) begin
      if (i_rst) begin
         sp_v_q <= {1024{1'b0}};
         dn_v_q <= {1024{1'b0}};
         fp_ptr_q <= 5'h00;
         l2m_v_q <= 1'b0;
         l2m_line_q <= 26'h0000000;
         l2m_data_q <= {2*`BPU_MKW{1'b0}};
         for (i = 0; i < 1024; i = i + 1)
            dp_mem[i] <= `BPU_DP_INIT;
      end else begin
         l2m_v_q <= i_evict_valid && i_evict_code_only;
         if (i_evict_valid) begin
            l2m_line_q <= i_evict_line;
            l2m_data_q <= {mk(sp_v_q[{i_evict_line[8:0], 1'b1}],
                              sp_mem[{i_evict_line[8:0], 1'b1}]),
                           mk(sp_v_q[{i_evict_line[8:0], 1'b0}],
                              sp_mem[{i_evict_line[8:0], 1'b0}])};
         end
         // Refill wins over sparse training; far-page slots are not carried
         if (i_fill_valid) begin
            sp_mem[{fi, 1'b0}] <= {fm0[27:12], 5'h00, fm0[11:0]};
            sp_mem[{fi, 1'b1}] <= {fm1[27:12], 5'h00, fm1[11:0]};
            sp_v_q[{fi, 1'b0}] <= i_fill_mark_ok && fm0[`BPU_MK_V] &&
                                  !fm0[`BPU_MK_FAR];
            sp_v_q[{fi, 1'b1}] <= i_fill_mark_ok && fm1[`BPU_MK_V] &&
                                  !fm1[`BPU_MK_FAR];
         end else if (u_wr && in_sp) begin
            sp_mem[{ul, sp_slot}] <= u_ent;
            sp_v_q[{ul, sp_slot}] <= 1'b1;
         end
         if (u_wr && !in_sp) begin
            dn_mem[{ud, dn_slot}] <= u_ent;
            dn_v_q[{ud, dn_slot}] <= 1'b1;
         end
         if (u_wr && u_far) begin
            fp_mem[u_fpi] <= i_upd_tgt[`BPU_FP_HI:`BPU_FP_LO];
            if (!u_reuse)
               fp_ptr_q <= fp_ptr_q + 5'h01;
         end
         if (u_wr && u_ita)
            it_mem[it_idx(i_upd_addr, i_upd_ghist)] <= i_upd_tgt;
         // Saturating counters only train dynamic conditionals
         if (i_upd_valid && u_cond && hit && old[`BPU_E_DYN]) begin
            if (i_upd_taken && dp_mem[u_dp] != 2'h3)
               dp_mem[u_dp] <= dp_mem[u_dp] + 2'h1;
            else if (!i_upd_taken && dp_mem[u_dp] != 2'h0)
               dp_mem[u_dp] <= dp_mem[u_dp] - 2'h1;
         end
      end
   end

endmodule // bpu_branch_prediction_unit

// ---- testbench/bpu_branch_prediction_unit_checker.sv ----
`timescale 1ns/1ps
`include "bpu_consts.vh"
module bpu_branch_prediction_unit_checker (
   // Clock and reset
   input wire                 i_clk,
   input wire                 i_rst,
   // Fetch stream
   input wire                 o_fetch_valid,
   input wire [31:0]          o_fetch_addr,
   input wire [`BPU_GHW-1:0]  o_fetch_ghist,
   input wire [3:0]           o_fetch_ras_ptr,
   // Flush
   input wire                 i_mis_valid,
   input wire [31:0]          i_mis_addr,
   input wire                 i_mis_cond,
   input wire                 i_mis_taken,
   input wire [`BPU_GHW-1:0]  i_mis_ghist,
   input wire [3:0]           i_mis_ras_ptr,
   // Marker caching
   input wire                 i_evict_valid,
   input wire [25:0]          i_evict_line,
   input wire                 i_evict_code_only,
   input wire                 o_l2m_valid,
   input wire [25:0]          o_l2m_line
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   reg  [3:0] hold_q;
   wire [3:0] hold_d;
   // Counts the dead cycles still owed after a flush
   assign hold_d = i_mis_valid ? 4'hE :
                   (hold_q != 4'h0) ? hold_q - 4'h1 : 4'h0;
   always @(posedge i_clk) begin
      if (i_rst) begin
         hold_q <= 4'h0;
      end else begin
         hold_q <= hold_d;
      end
   end

   a_reset_state: assert property (disable iff (1'b0) // RESET
      i_rst |=> o_fetch_addr == 32'h0 && o_fetch_valid && !o_l2m_valid)
      else $error("state after reset wrong");
   a_seq_step: assert property (o_fetch_valid && !i_mis_valid |=>
      !o_fetch_valid || o_fetch_addr == {$past(o_fetch_addr[31:5]) + 27'h1,
      5'h0}) else $error("fetch did not step to next block");
   a_flush_addr: assert property (i_mis_valid |=>
      !o_fetch_valid && o_fetch_addr == $past(i_mis_addr))
      else $error("flush address not taken");
   a_flush_hold: assert property (hold_q != 4'h0 |-> !o_fetch_valid)
      else $error("fetch resumed too early after flush");
   a_flush_hist: assert property (i_mis_valid && i_mis_cond |=>
      o_fetch_ghist == {$past(i_mis_ghist[24:0]), $past(i_mis_taken)})
      else $error("history not restored on flush");
   a_flush_stack: assert property (i_mis_valid |=>
      o_fetch_ras_ptr == $past(i_mis_ras_ptr))
      else $error("return stack pointer not restored");
   a_evict_out: assert property (i_evict_valid && i_evict_code_only |=>
      o_l2m_valid && o_l2m_line == $past(i_evict_line))
      else $error("markers not sent on eviction");
   a_evict_skip: assert property (i_evict_valid && !i_evict_code_only |=>
      !o_l2m_valid) else $error("markers sent for mixed line");
   a_marker_cause: assert property (o_l2m_valid |->
      $past(i_evict_valid) && $past(i_evict_code_only))
      else $error("marker pulse without eviction");
endmodule // bpu_branch_prediction_unit_checker

bind bpu_branch_prediction_unit bpu_branch_prediction_unit_checker
   i_bpu_branch_prediction_unit_checker (.i_clk, .i_rst, .o_fetch_valid,
   .o_fetch_addr, .o_fetch_ghist, .o_fetch_ras_ptr, .i_mis_valid, .i_mis_addr,
   .i_mis_cond, .i_mis_taken, .i_mis_ghist, .i_mis_ras_ptr, .i_evict_valid,
   .i_evict_line, .i_evict_code_only, .o_l2m_valid, .o_l2m_line);

// ---- testbench/bpu_retire_model.sv ----
`timescale 1ns/1ps
module bpu_retire_model (
   // Clock and reset
   input  wire i_clk,
   input  wire i_rst,
   // Pace from the bench
   input  wire i_stall,
   input  wire i_slow,
   // Retirement toward the predictor
   output reg  o_ret_valid
);
   reg [2:0] pace_q;
   // Fast pace frees an entry every second cycle, slow one in eight
   always @(posedge i_clk) begin
      if (i_rst) begin
         pace_q      <= 3'h0;
         o_ret_valid <= 1'b0;
      end else begin
         pace_q      <= pace_q + 3'h1;
         o_ret_valid <= !i_stall && (i_slow ? pace_q == 3'h7 : pace_q[0]);
      end
   end
endmodule // bpu_retire_model

// ---- testbench/bpu_branch_prediction_unit_tb.sv ----
`timescale 1ns/1ps
`include "bpu_consts.vh"
module bpu_branch_prediction_unit_tb;
   reg         i_clk, i_rst, i_pd_valid, i_pd_direct, i_pd_imm_done;
   reg         i_upd_valid, i_upd_taken, i_mis_valid, i_mis_cond;
   reg         i_mis_taken, i_evict_valid, i_evict_code_only;
   reg         i_fill_valid, i_fill_mark_ok, stall, slow;
   reg  [31:0] i_pd_addr, i_pd_tgt, i_upd_addr, i_upd_tgt, i_mis_addr;
   reg  [31:0] i_mis_ras_top, n, mismatches, checks;
   reg  [25:0] i_mis_ghist, i_upd_ghist, i_evict_line, i_fill_line;
   reg  [3:0]  i_upd_len, i_mis_fw_idx, i_mis_ras_ptr;
   reg  [2:0]  i_upd_kind;
   reg  [57:0] i_fill_mark;
   reg  [28:0] mk;
   wire        o_fetch_valid, o_l2m_valid, i_ret_valid;
   wire [31:0] o_fetch_addr, o_fetch_ras_top;
   wire [3:0]  o_fetch_fw_idx, o_fetch_ras_ptr;
   wire [25:0] o_fetch_ghist, o_l2m_line;
   wire [57:0] o_l2m_data;

   bpu_branch_prediction_unit i_bpu_branch_prediction_unit (.i_clk, .i_rst,
      .o_fetch_valid, .o_fetch_addr, .o_fetch_fw_idx, .o_fetch_ghist,
      .o_fetch_ras_ptr, .o_fetch_ras_top, .i_pd_valid, .i_pd_addr,
      .i_pd_direct, .i_pd_imm_done, .i_pd_tgt, .i_upd_valid, .i_upd_addr,
      .i_upd_kind, .i_upd_len, .i_upd_taken, .i_upd_tgt, .i_upd_ghist,
      .i_mis_valid, .i_mis_addr, .i_mis_cond, .i_mis_taken, .i_mis_ghist,
      .i_mis_fw_idx, .i_mis_ras_ptr, .i_mis_ras_top, .i_ret_valid,
      .i_evict_valid, .i_evict_line, .i_evict_code_only, .o_l2m_valid,
      .o_l2m_line, .o_l2m_data, .i_fill_valid, .i_fill_line, .i_fill_mark_ok,
      .i_fill_mark);
   bpu_retire_model i_bpu_retire_model (.i_clk, .i_rst, .i_stall(stall),
      .i_slow(slow), .o_ret_valid(i_ret_valid));

   task automatic chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 32'h1;
         if (got !== exp) begin
            mismatches = mismatches + 32'h1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // Counts dead fetch cycles, bounded against a stuck stall
   task automatic gap(output [31:0] lows);
      begin
         lows = 32'h0;
         while (o_fetch_valid !== 1'b1 && lows < 32'h190) begin
            lows = lows + 32'h1;
            @(negedge i_clk);
         end
      end
   endtask
   task automatic hop(input string what, input [31:0] t, input [31:0] bub);
      begin
         @(negedge i_clk);
         gap(n);
         chk(what, bub, n);
         chk(what, t, o_fetch_addr);
      end
   endtask
   // Checkpoints go back as fetch last showed them
   task automatic flush(input [31:0] a, input cond);
      begin
         {i_mis_valid, i_mis_addr, i_mis_cond, i_mis_taken} = {1'b1, a, cond, cond};
         i_mis_fw_idx = o_fetch_fw_idx;
         i_mis_ras_ptr = o_fetch_ras_ptr;
         i_mis_ras_top = o_fetch_ras_top;
         @(negedge i_clk);
         i_mis_valid = 1'b0;
         gap(n);
         chk("flush gap", 32'hE, n);
         chk("flush addr", a, o_fetch_addr);
      end
   endtask
   task automatic train(input [31:0] a, input [2:0] k, input [3:0] len,
                        input [31:0] t, input tk);
      begin
         {i_upd_valid, i_upd_addr, i_upd_kind, i_upd_len} = {1'b1, a, k, len};
         {i_upd_tgt, i_upd_taken} = {t, tk};
         @(negedge i_clk);
         i_upd_valid = 1'b0;
         @(negedge i_clk);
      end
   endtask
   task automatic fix(input imm, input [31:0] t, input [31:0] bub);
      begin
         {i_pd_valid, i_pd_direct, i_pd_imm_done} = {2'b11, imm};
         @(negedge i_clk);
         i_pd_valid = 1'b0;
         gap(n);
         chk("fix gap", bub, n);
         chk("fix addr", t, o_fetch_addr);
         @(negedge i_clk);
      end
   endtask

   // Runs out of a branchless stream with retirement held off
   task automatic t_fifo;
      begin
         n = 32'h0;
         repeat (60) begin
            if (o_fetch_valid === 1'b1) n = n + 32'h1;
            @(negedge i_clk);
         end
         chk("window fetches", 32'h20, n);
         chk("stall addr", 32'h400, o_fetch_addr);
         stall = 1'b0;
         slow = 1'b1;
         gap(n);
         chk("resume", 32'h1, {31'h0, o_fetch_valid});
         slow = 1'b0;
      end
   endtask
   task automatic t_branches;
      begin
         train(32'h1004, `BPU_K_JMP, 4'h2, 32'h1200, 1'b1);
         flush(32'h1000, 1'b0);
         hop("sparse taken", 32'h1200, 32'h1);
         {i_pd_addr, i_pd_tgt} = {32'h1004, 32'h1400};
         fix(1'b0, 32'h1220, 32'h0);
         fix(1'b1, 32'h1400, 32'h4);
         flush(32'h2000, 1'b0);
         hop("cond unmarked", 32'h2020, 32'h0);
         train(32'h2008, `BPU_K_COND, 4'h2, 32'h2300, 1'b1);
         flush(32'h2000, 1'b0);
         hop("cond taken", 32'h2300, 32'h1);
         train(32'h4004, `BPU_K_IND, 4'h2, 32'h30000100, 1'b1);
         flush(32'h4000, 1'b0);
         hop("indirect far", 32'h30000100, 32'h4);
         train(32'h5004, `BPU_K_CALL, 4'h5, 32'h5009, 1'b1);
         train(32'h5010, `BPU_K_RET, 4'h1, 32'h5009, 1'b1);
         flush(32'h5000, 1'b0);
         hop("zero call", 32'h5009, 32'h1);
         hop("short return", 32'h5009, 32'h1);
      end
   endtask
   // Second eviction is a mixed line: no marker may leave
   task automatic t_markers;
      begin
         mk = {1'b1, 6'h04, `BPU_K_JMP, 3'h0, 4'h2, 12'h200};
         {i_evict_valid, i_evict_line, i_evict_code_only} = {1'b1, 26'h40, 1'b1};
         @(negedge i_clk);
         i_evict_code_only = 1'b0;
         chk("marker line", {5'h1, 1'b1, 26'h40}, {5'h1, o_l2m_valid, o_l2m_line});
         chk("marker slot", {3'h0, mk}, {3'h0, o_l2m_data[28:0]});
         @(negedge i_clk);
         i_evict_valid = 1'b0;
         {i_fill_valid, i_fill_line, i_fill_mark_ok} = {1'b1, 26'h70, 1'b1};
         i_fill_mark = {29'h0, mk};
         @(negedge i_clk);
         i_fill_valid = 1'b0;
         flush(32'h1C00, 1'b0);
         hop("marker restored", 32'h1200, 32'h1);
         {i_fill_valid, i_fill_line, i_fill_mark_ok} = {1'b1, 26'h78, 1'b0};
         @(negedge i_clk);
         i_fill_valid = 1'b0;
         flush(32'h1E00, 1'b0);
         hop("marker dropped", 32'h1E20, 32'h0);
         flush(32'h6000, 1'b1);
      end
   endtask

   task conclude;
      begin
         $display("checks %0d mismatches %0d", checks, mismatches);
         if (mismatches == 32'h0 && checks > 32'h0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask

   // Free-running core clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Zero history keeps table indexes equal to training
   initial begin
      {mismatches, checks, stall, slow, i_rst} = {64'h0, 3'b101};
      {i_pd_valid, i_pd_direct, i_pd_imm_done, i_pd_addr, i_pd_tgt} = '0;
      {i_upd_valid, i_upd_addr, i_upd_kind, i_upd_len, i_upd_taken} = '0;
      {i_upd_tgt, i_upd_ghist, i_mis_valid, i_mis_addr, i_mis_cond} = '0;
      {i_mis_taken, i_mis_ghist, i_mis_fw_idx, i_mis_ras_ptr} = '0;
      {i_mis_ras_top, i_evict_valid, i_evict_line, i_evict_code_only} = '0;
      {i_fill_valid, i_fill_line, i_fill_mark_ok, i_fill_mark, mk} = '0;
      repeat (3) @(negedge i_clk);
      i_rst = 1'b0;
      t_fifo;
      t_branches;
      t_markers;
      conclude;
   end
   // Whole run needs well under two thousand cycles
   initial begin
      #20000;
      mismatches = mismatches + 32'h1;
      conclude;
   end
endmodule // bpu_branch_prediction_unit_tb
